// ---- lsc_sync_control.sv ----
// Module: LIN hardware sync control unit with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module lsc_sync_control
(
  input  wire logic        mclk,          // 125 MHz clock
  input  wire logic        rst,           // Synchronous reset, active high
  input  wire logic [31:0] s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output var  logic        s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output var  logic        s_axi_wready,  // Write data ready
  output var  logic [1:0]  s_axi_bresp,   // Write response
  output var  logic        s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [31:0] s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output var  logic        s_axi_arready, // Read address ready
  output var  logic [31:0] s_axi_rdata,   // Read data
  output var  logic [1:0]  s_axi_rresp,   // Read response
  output var  logic        s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic        linRxd,        // Bus level from transceiver
  output var  logic        linTxd,        // Transmit to transceiver
  input  wire logic        uartTxd,       // UART transmit
  output var  logic        uartRxd,       // UART receive, possibly gated
  input  wire logic        testTxPin,     // Test mode transmit source
  output var  logic        testRxPin,     // Test mode receive copy
  output var  logic        irq            // Level interrupt
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [15:0] ctrlQ;
  logic [7:0]  edgeQ;
  logic [5:0]  statusQ;
  logic [5:0]  ienQ;
  logic [5:0]  permit;
  logic [5:0]  events;
  logic [5:0]  clrBits;
  logic [4:0]  tickCnt_q;
  logic        tick;
  logic        busPrev_q;
  logic        fallEdge;
  logic        riseEdge;
  logic [3:0]  fallCnt_q;
  logic [3:0]  riseCnt_q;
  logic        running_q;
  logic        syncDone_q;
  logic [15:0] timer_q;
  logic [11:0] lowTicks_q;
  logic        awHeld_q;
  logic        wHeld_q;
  logic [31:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;
  logic        unitOn;
  logic [3:0]  stopCnt;
  logic        startHit;
  logic        stopHit;

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  // Address and data are taken independently and held until both are here
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 32'h0000_0000;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lsc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr_q)
          lsc_pkg::CTRL0_ADDR, lsc_pkg::EDGE_ADDR,
          lsc_pkg::ICLR_ADDR,  lsc_pkg::IEN_ADDR: s_axi_bresp <= lsc_pkg::RESP_OKAY;
          default:                                 s_axi_bresp <= lsc_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  // One read at a time; data captured the edge the address is taken
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lsc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= lsc_pkg::RESP_OKAY;
        case (s_axi_araddr)
          lsc_pkg::STATUS_ADDR: s_axi_rdata <= {26'h0, statusQ};
          lsc_pkg::CTRL0_ADDR:  s_axi_rdata <= {16'h0, ctrlQ};
          lsc_pkg::TIMER_ADDR:  s_axi_rdata <= {16'h0, timer_q};
          lsc_pkg::EDGE_ADDR:   s_axi_rdata <= {24'h0, edgeQ};
          lsc_pkg::IEN_ADDR:    s_axi_rdata <= {26'h0, ienQ};
          lsc_pkg::ICLR_ADDR:   s_axi_rdata <= 32'h0000_0000;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= lsc_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Control, edge count and interrupt enable registers
  // ==========================================================================
  // Reset bit is only a one-cycle command, so it drops the edge after it is seen
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrlQ <= lsc_pkg::CTRL0_RESET;
      edgeQ <= lsc_pkg::EDGE_RESET;
      ienQ  <= lsc_pkg::IEN_RESET;
    end
    else
    begin
      ctrlQ[lsc_pkg::C_RESET] <= 1'b0;
      if (doWrite && awAddr_q == lsc_pkg::CTRL0_ADDR)
      begin
        // Reserved positions are not stored, so they always read zero
        if (wStrb_q[0])
          ctrlQ[7:0]  <= wData_q[7:0] & lsc_pkg::CTRL0_WMASK[7:0];
        if (wStrb_q[1])
          ctrlQ[15:8] <= wData_q[15:8] & lsc_pkg::CTRL0_WMASK[15:8];
      end
      if (doWrite && awAddr_q == lsc_pkg::EDGE_ADDR && wStrb_q[0])
        edgeQ <= wData_q[7:0];
      if (doWrite && awAddr_q == lsc_pkg::IEN_ADDR && wStrb_q[0])
        ienQ <= wData_q[5:0];
    end
  end

  // ==========================================================================
  // 5 MHz timebase and bus edge detection
  // ==========================================================================
  // The timebase is a tick enable, so the whole unit stays in one domain
  assign tick     = (tickCnt_q == 5'(lsc_pkg::TICK_CYC - 1));
  assign fallEdge = busPrev_q && !linRxd;
  assign riseEdge = !busPrev_q && linRxd;
  assign unitOn   = ctrlQ[lsc_pkg::C_ENABLE];
  assign stopCnt  = edgeQ[7:4];
  assign startHit = unitOn && fallEdge && (fallCnt_q + 4'h1 == edgeQ[3:0]);
  assign stopHit  = unitOn && running_q &&
                    (ctrlQ[lsc_pkg::C_STOP_RISE] ? (riseEdge && riseCnt_q + 4'h1 == stopCnt)
                                                 : (fallEdge && fallCnt_q + 4'h1 == stopCnt));

  always_ff @(posedge mclk)
  begin
    if (rst || ctrlQ[lsc_pkg::C_RESET])
      tickCnt_q <= 5'h00;
    else
      tickCnt_q <= tick ? 5'h00 : tickCnt_q + 5'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      busPrev_q <= 1'b1;
    else
      busPrev_q <= linRxd;
  end

  // ==========================================================================
  // Edge counters
  // ==========================================================================
  // Cleared after a stop; the sync byte's later edges are then counted again from zero
  always_ff @(posedge mclk)
  begin
    if (rst || ctrlQ[lsc_pkg::C_RESET] || ctrlQ[lsc_pkg::C_EDGE_CLR] || !unitOn || stopHit)
    begin
      fallCnt_q <= 4'h0;
      riseCnt_q <= 4'h0;
    end
    else
    begin
      if (fallEdge && fallCnt_q != 4'hF)
        fallCnt_q <= fallCnt_q + 4'h1;
      if (riseEdge && riseCnt_q != 4'hF)
        riseCnt_q <= riseCnt_q + 4'h1;
    end
  end

  // ==========================================================================
  // Sync timer and break timer
  // ==========================================================================
  always_ff @(posedge mclk)
  begin
    if (rst || ctrlQ[lsc_pkg::C_RESET])
    begin
      running_q <= 1'b0;
      timer_q   <= 16'h0000;
    end
    else if (!unitOn)
      running_q <= 1'b0;
    else if (stopHit)
      running_q <= 1'b0;
    else if (startHit)
    begin
      running_q <= 1'b1;
      timer_q   <= 16'h0000;
    end
    else if (running_q && tick)
      timer_q <= timer_q + 16'h0001;
  end

  // Low time of the bus, measured in ticks; saturates at overflow
  always_ff @(posedge mclk)
  begin
    if (rst || ctrlQ[lsc_pkg::C_RESET] || !unitOn || linRxd)
      lowTicks_q <= 12'h000;
    else if (tick && lowTicks_q != 12'hFFF)
      lowTicks_q <= lowTicks_q + 12'h001;
  end

  // Sync byte seen: opens the UART gate until a break reaches the compare threshold
  always_ff @(posedge mclk)
  begin
    if (rst || ctrlQ[lsc_pkg::C_RESET] || events[lsc_pkg::S_BRK_CMP])
      syncDone_q <= 1'b0;
    else if (stopHit)
      syncDone_q <= 1'b1;
  end

  // ==========================================================================
  // Events, sticky status and interrupt
  // ==========================================================================
  always_comb
  begin
    events = 6'h00;
    events[lsc_pkg::S_BRK_CMP]  = unitOn && tick && (lowTicks_q + 12'h001 == lsc_pkg::BRK_CMP_TICKS);
    events[lsc_pkg::S_START]    = startHit;
    events[lsc_pkg::S_STOP]     = stopHit;
    events[lsc_pkg::S_TMR_CMP]  = running_q && tick && (timer_q + 16'h0001 == lsc_pkg::TMR_CMP_VALUE);
    events[lsc_pkg::S_BRK_ERR]  = unitOn && tick && !linRxd && (lowTicks_q == 12'hFFE);
    events[lsc_pkg::S_RST_DONE] = ctrlQ[lsc_pkg::C_RESET];
  end

  // Disable bits mask when set, enable bits pass when set
  always_comb
  begin
    permit = 6'h3F;
    permit[lsc_pkg::S_BRK_CMP] = !ctrlQ[lsc_pkg::C_BRKCMP_DIS];
    permit[lsc_pkg::S_BRK_ERR] = !ctrlQ[lsc_pkg::C_BRKERR_DIS];
    permit[lsc_pkg::S_STOP]    = ctrlQ[lsc_pkg::C_STOP_IEN];
    permit[lsc_pkg::S_START]   = ctrlQ[lsc_pkg::C_START_IEN];
  end

  assign clrBits = (doWrite && awAddr_q == lsc_pkg::ICLR_ADDR && wStrb_q[0]) ? wData_q[5:0] : 6'h00;

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge mclk)
  begin
    if (rst)
      statusQ <= 6'h00;
    else if (ctrlQ[lsc_pkg::C_RESET])
      statusQ <= 6'h00 | events;
    else
      statusQ <= (statusQ & ~clrBits) | events;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(statusQ & ienQ & permit);
  end

  // ==========================================================================
  // Transceiver and UART routing
  // ==========================================================================
  // Test mode cuts the UART off completely; its receive idles high
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      linTxd    <= 1'b1;
      uartRxd   <= 1'b1;
      testRxPin <= 1'b1;
    end
    else if (ctrlQ[lsc_pkg::C_TEST_MODE])
    begin
      linTxd    <= testTxPin;
      testRxPin <= linRxd;
      uartRxd   <= 1'b1;
    end
    else
    begin
      linTxd    <= uartTxd;
      testRxPin <= 1'b1;
      uartRxd   <= (ctrlQ[lsc_pkg::C_GATE_UART] && !syncDone_q) ? 1'b1
                                                                 : linRxd;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence sWriteReady;
    awHeld_q && wHeld_q && !s_axi_bvalid;
  endsequence

  sequence sRespond;
    s_axi_bvalid ##0 !awHeld_q;
  endsequence

  a_write_resp: assert property (@(posedge mclk) disable iff (rst)
    sWriteReady |=> sRespond)
    else $error("write response missing");

  a_ctrl_reset: assert property (@(posedge mclk)
    rst |=> ctrlQ == 16'h0000 && edgeQ == 8'h32)
    else $error("control not at reset value");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    (ctrlQ & ~lsc_pkg::CTRL0_WMASK) == 16'h0000)
    else $error("reserved control bits set");

  a_reset_selfclear: assert property (@(posedge mclk) disable iff (rst)
    ctrlQ[0] |=> !ctrlQ[0] && !running_q && timer_q == 16'h0000)
    else $error("unit reset did not complete");

  a_counter_hold: assert property (@(posedge mclk) disable iff (rst)
    ctrlQ[1] |=> fallCnt_q == 4'h0 && riseCnt_q == 4'h0)
    else $error("edge counters not held clear");

  a_disabled_idle: assert property (@(posedge mclk) disable iff (rst)
    !ctrlQ[2] |=> !running_q && lowTicks_q == 12'h000)
    else $error("unit active while disabled");

  a_test_route: assert property (@(posedge mclk) disable iff (rst)
    ctrlQ[9] |=> linTxd == $past(testTxPin) && testRxPin == $past(linRxd) && uartRxd)
    else $error("test mode routing wrong");

  a_normal_route: assert property (@(posedge mclk) disable iff (rst)
    !ctrlQ[9] |=> linTxd == $past(uartTxd) && testRxPin)
    else $error("normal routing wrong");

  a_uart_gate: assert property (@(posedge mclk) disable iff (rst)
    !ctrlQ[9] && ctrlQ[8] && !syncDone_q |=> uartRxd)
    else $error("UART receive not gated");

  a_uart_follow: assert property (@(posedge mclk) disable iff (rst)
    !ctrlQ[9] && !ctrlQ[8] |=> uartRxd == $past(linRxd))
    else $error("UART receive not following bus");

  a_stop_mask: assert property (@(posedge mclk) disable iff (rst)
    statusQ[2] && !ctrlQ[4] && !ctrlQ[3] && (statusQ & 6'h39) == 6'h00 |=> !irq)
    else $error("stop interrupt not masked");

  a_brk_mask: assert property (@(posedge mclk) disable iff (rst)
    statusQ == 6'h01 |=> irq == $past(!ctrlQ[11] && ienQ[0]))
    else $error("break compare interrupt gating wrong");

  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    |(statusQ & ienQ & permit) |=> irq)
    else $error("interrupt not raised");

  a_stop_edge: assert property (@(posedge mclk) disable iff (rst)
    stopHit |-> (ctrlQ[7] ? riseEdge : fallEdge) ##1 !running_q && statusQ[2])
    else $error("stop on wrong edge type");

endmodule
`default_nettype wire

// ---- lsc_pkg.sv ----
// Package: register map, field positions, reset values and timing of the sync control unit
package lsc_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [31:0] STATUS_ADDR  = 32'hFFFF0780; // sync_status_flags, read only
  localparam logic [31:0] CTRL0_ADDR   = 32'hFFFF0784; // sync_control_0
  localparam logic [31:0] TIMER_ADDR   = 32'hFFFF0788; // sync_timer_value, read only
  localparam logic [31:0] EDGE_ADDR    = 32'hFFFF078C; // sync_edge_count_control
  localparam logic [31:0] ICLR_ADDR    = 32'hFFFF0790; // interrupt clear, write only
  localparam logic [31:0] IEN_ADDR     = 32'hFFFF0794; // interrupt enable

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] CTRL0_RESET  = 16'h0000;
  localparam logic [7:0]  EDGE_RESET   = 8'h32;      // stop count 3, start count 2
  localparam logic [5:0]  IEN_RESET    = 6'h3F;      // control bits alone gate by default
  localparam logic [15:0] CTRL0_WMASK  = 16'h0F9F;   // bits 15..12 and 6..5 read as zero

  // ==========================================================================
  // sync_control_0 fields
  // ==========================================================================
  localparam int C_RESET      = 0;
  localparam int C_EDGE_CLR   = 1;
  localparam int C_ENABLE     = 2;
  localparam int C_START_IEN  = 3;
  localparam int C_STOP_IEN   = 4;
  localparam int C_STOP_RISE  = 7;
  localparam int C_GATE_UART  = 8;
  localparam int C_TEST_MODE  = 9;
  localparam int C_BRKERR_DIS = 10;
  localparam int C_BRKCMP_DIS = 11;

  // ==========================================================================
  // sync_status_flags fields
  // ==========================================================================
  localparam int S_BRK_CMP    = 0;
  localparam int S_START      = 1;
  localparam int S_STOP       = 2;
  localparam int S_TMR_CMP    = 3;
  localparam int S_BRK_ERR    = 4;
  localparam int S_RST_DONE   = 5;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_NS       = 8;                   // mclk period at 125 MHz
  localparam int TICK_NS      = 200;                 // 5 MHz sync timebase period
  localparam int TICK_CYC     = TICK_NS / CLK_NS;    // 25 cycles per tick
  localparam logic [11:0] BRK_CMP_TICKS = 12'h800;   // break length threshold in ticks
  localparam logic [15:0] TMR_CMP_VALUE = 16'hFFFF;  // timer compare value

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- lsc_lin_master.sv ----
// LIN bus master model that drives the bus level seen through the transceiver
`timescale 1ns/1ns
`default_nettype none
module lsc_lin_master
(
  input  wire logic mclk,  // Core clock
  output var  logic linRxd // Bus level, pull-up when idle
);
  int pos = 99; // Sync field bit index, -1 in break, 99 idle
  // Released bus rests at the pull-up level
  initial linRxd = 1'b1;
  // Break, delimiter, then the sync byte LSB first with start and stop bits
  task automatic frame(input int brk, input int bitc);
    logic [9:0] f;
    f = {1'b1, 8'h55, 1'b0};
    pos = -1;
    linRxd <= 1'b0;
    repeat (brk) @(posedge mclk);
    linRxd <= 1'b1;
    repeat (bitc) @(posedge mclk);
    for (int i = 0; i < 10; i++)
    begin
      pos = i;
      linRxd <= f[i];
      repeat (bitc) @(posedge mclk);
    end
    pos = 99;
  endtask
  // Plain level for the pass-through checks
  task automatic lvl(input logic v);
    linRxd <= v;
  endtask
endmodule
`default_nettype wire

// ---- lsc_sync_control_bench.sv ----
// Self-checking bench for the LIN sync control unit
`timescale 1ns/1ns
`default_nettype none
module lsc_sync_control_bench;
  localparam int BITC = 100; // LIN bit time in mclk cycles
  logic        mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, linRxd, linTxd, uartTxd, uartRxd, testTxPin, testRxPin, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] c;
  logic [15:0] cw [4] = '{16'h011C, 16'h0084, 16'h0006, 16'h0000};
  int          error_cnt = 0;
  int          n_checks = 0;
  int          lowEarly, lowLate;

  lsc_sync_control lsc_sync_control_i
  (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .linRxd, .linTxd, .uartTxd,
    .uartRxd, .testTxPin, .testRxPin, .irq
  );
  lsc_lin_master lm (.mclk(mclk), .linRxd(linRxd));

  // ==========================================================================
  // Clock, watchdog and receive-path monitor
  // ==========================================================================
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Whole sequence needs about 63k cycles
  initial
  begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
  // Lows before the stop edge must be gated, later ones must pass
  always @(posedge mclk)
  begin
    if (uartRxd === 1'b0 && lm.pos < 2) lowEarly++;
    if (uartRxd === 1'b0 && lm.pos > 3 && lm.pos < 99) lowLate++;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Tick count between two edges, one tick of slack for sync delay
  function automatic logic inr(input logic [31:0] t, input int bits);
    int e;
    e = bits * BITC / lsc_pkg::TICK_CYC;
    return (t + 1 >= e) && (t <= e + 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write: AW and W offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic tb;
    int   n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    n = 0;
    while (!tb && n < 100)
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      tb = (s_axi_bvalid === 1'b1);
    end
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    chk("bvalid", tb, 1);
  endtask
  task automatic rd(input logic [31:0] a);
    logic tr;
    int   n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    n = 0;
    while (!tr && n < 100)
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      tr = (s_axi_rvalid === 1'b1);
    end
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    resp = s_axi_rresp;
    chk("rvalid", tr, 1);
  endtask
  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, v, e);
  endtask
  // Registered irq lags its causes by two edges
  task automatic st;
    repeat (4) @(posedge mclk);
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    {uartTxd, testTxPin} = 2'h3;
    seed = 32'h4D57;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rc("ctrl", lsc_pkg::CTRL0_ADDR, 32'h0);
    rc("edge", lsc_pkg::EDGE_ADDR, 32'h32);
    rc("ien", lsc_pkg::IEN_ADDR, 32'h3F);
    rc("status", lsc_pkg::STATUS_ADDR, 32'h0);
    // Random words; reserved bits kept zero, reset bit reads back zero
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      wr(lsc_pkg::CTRL0_ADDR, seed & 32'h0F9F);
      rc("ctrl", lsc_pkg::CTRL0_ADDR, seed & 32'h0F9E);
      wr(lsc_pkg::EDGE_ADDR, seed >> 8);
      rc("edge", lsc_pkg::EDGE_ADDR, {24'h0, seed[15:8]});
    end
    rd(32'hFFFF07A0);
    chk("rresp", resp, lsc_pkg::RESP_SLVERR);
    chk("rdata", v, 0);
    wr(32'hFFFF07A0, 32'h1);
    chk("bresp", resp, lsc_pkg::RESP_SLVERR);
    wr(lsc_pkg::EDGE_ADDR, 32'h32);
    wr(lsc_pkg::ICLR_ADDR, 32'h3F);
    $display("Done: registers");
    // Normal path, then test pins prepared before test mode
    for (int m = 0; m < 2; m++)
    begin
      testTxPin <= 1'b1;
      wr(lsc_pkg::CTRL0_ADDR, m ? 32'h200 : 32'h0);
      for (int i = 0; i < 6; i++)
      begin
        seed = lfsr(seed);
        @(posedge mclk);
        uartTxd <= seed[0];
        testTxPin <= seed[1];
        lm.lvl(seed[2]);
        repeat (2) @(posedge mclk);
        chk("linTxd", linTxd, m ? seed[1] : seed[0]);
        chk("uartRxd", uartRxd, m ? 1'b1 : seed[2]);
        chk("testRxPin", testRxPin, m ? seed[2] : 1'b1);
      end
    end
    lm.lvl(1'b1);
    uartTxd <= 1'b1;
    $display("Done: pass-through");
    // Frames under gate, edge type, counter clear and disable
    for (int k = 0; k < 4; k++)
    begin
      c = cw[k];
      // Tail edges of the last sync byte stay counted, so clear before each frame
      wr(lsc_pkg::CTRL0_ADDR, c | 16'h0002);
      wr(lsc_pkg::CTRL0_ADDR, c);
      lowEarly = 0;
      lowLate = 0;
      lm.frame(13 * BITC, BITC);
      st();
      chk("irq", irq, c[4:3] != 0);
      rc("status", lsc_pkg::STATUS_ADDR, c[2:1] == 2'b10 ? 32'h6 : 32'h0);
      chk("gated", lowEarly == 0, c[8]);
      chk("open", lowLate > 0, 1);
      rd(lsc_pkg::TIMER_ADDR);
      if (k < 2) chk("timer", inr(v, c[7] ? 3 : 2), 1);
      wr(lsc_pkg::ICLR_ADDR, 32'h3F);
      st();
      chk("irq", irq, 0);
    end
    $display("Done: frames");
    wr(lsc_pkg::CTRL0_ADDR, 32'h1);
    rc("ctrl", lsc_pkg::CTRL0_ADDR, 32'h0);
    rc("status", lsc_pkg::STATUS_ADDR, 32'h20);
    chk("irq", irq, 1);
    wr(lsc_pkg::IEN_ADDR, 32'h0);
    st();
    chk("irq", irq, 0);
    wr(lsc_pkg::IEN_ADDR, 32'h3F);
    st();
    chk("irq", irq, 1);
    wr(lsc_pkg::ICLR_ADDR, 32'h20);
    st();
    chk("irq", irq, 0);
    $display("Done: unit reset and interrupt mask");
    // Long break reaches the compare threshold with its interrupt masked
    wr(lsc_pkg::CTRL0_ADDR, 32'h0804);
    lm.frame(52000, BITC);
    st();
    chk("irq", irq, 0);
    rd(lsc_pkg::STATUS_ADDR);
    chk("brkcmp", v[0], 1);
    wr(lsc_pkg::CTRL0_ADDR, 32'h0404);
    st();
    chk("irq", irq, 1);
    $display("Done: break compare");
    close_out();
  end
endmodule
`default_nettype wire
